// ===== include/bridge_pkg.sv
// Shared constants and types for the USB to wireless MAC adaptation bridge.
// Assumes every packet starts with one header word and ends on a word flagged last.
// Notes on behaviour
// - Host OUT: USB frames become MAC units.
// - Token and data never share one unit.
// - Host IN: MAC units become USB frames.
// - Classify transfers from the packet header.
// - Host OUT: buffer token, data, handshake packets.
// - Host IN: buffer data and handshake separately.
// - Pass control info with units for scheduling.
// - Device OUT: MAC units become USB frames.
// - Device IN: buffer data/handshake, form units.
// - Device OUT: each packet type own buffer.
// - USB 3.0 both ways: request private reservation.
// - May reorder packets; restore order on receive.
// - Host both revisions; device per capability.
`default_nettype none
package bridge_pkg;
    // Bus and buffer geometry
    localparam int DATA_W     = 32;
    localparam int FIFO_W     = DATA_W + 1;
    localparam int FIFO_DEPTH = 16;
    localparam int NUM_Q      = 3;
    // Header word layout
    localparam int KIND_LSB   = 0;
    localparam int XFER_LSB   = 2;
    localparam int SEQ_LSB    = 4;
    localparam int SEQ_W      = 4;
    localparam int REV_BIT    = 8;
    typedef logic [SEQ_W-1:0] seq_t;
    localparam seq_t SEQ_ONE  = 4'h1;
    localparam seq_t SEQ_RST  = 4'h0;
    // Packet kinds; all but KIND_NONE also index the buffers
    localparam logic [1:0] KIND_TOKEN  = 2'h0;
    localparam logic [1:0] KIND_DATA   = 2'h1;
    localparam logic [1:0] KIND_HSHAKE = 2'h2;
    localparam logic [1:0] KIND_NONE   = 2'h3;
    // Transfer classes
    typedef enum logic [1:0] {
        XFER_CONTROL = 2'h0,
        XFER_ISOCH   = 2'h1,
        XFER_BULK    = 2'h2,
        XFER_INTR    = 2'h3
    } xfer_t;
endpackage
`default_nettype wire

// ===== hw/packet_fifo.sv
// Packet buffer with registered head word and valid/ready on both sides.
// Assumes one clock; the memory needs no reset since counts gate every read.
`default_nettype none
module packet_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0]    wp;
        logic [AW-1:0]    rp;
        logic [AW:0]      cnt;
        logic             hv;
        logic [WIDTH-1:0] hd;
    } st_t;

    st_t              s_reg;
    st_t              s_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             load;

    // Honest full: refuse once the store holds DEPTH words
    assign in_ready  = s_reg.cnt < (AW+1)'(DEPTH);
    assign push      = in_valid && in_ready;
    assign load      = (s_reg.cnt != '0) && (!s_reg.hv || out_ready);
    assign out_valid = s_reg.hv;
    assign out_data  = s_reg.hd;

    // Pointers, count and head register
    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.wp = AW'(s_reg.wp + 1'b1);
        end
        if (load) begin
            s_next.rp = AW'(s_reg.rp + 1'b1);
            s_next.hd = mem[s_reg.rp];
            s_next.hv = 1'b1;
        end else if (out_ready) begin
            s_next.hv = 1'b0;
        end
        s_next.cnt = (AW+1)'(s_reg.cnt + push - load);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Storage written only while space remains
    always_ff @(posedge clk) begin
        if (push) begin
            mem[s_reg.wp] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ===== hw/usb_wireless_adaptation_bridge.sv
// Protocol adaptation between a USB bus interface and a wireless MAC.
// Assumes packets arrive as a header word plus payload words, last word flagged,
// and that reorder_en only changes while no packet is in flight.
`default_nettype none
module usb_wireless_adaptation_bridge (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // Static configuration
    input  wire logic                          host_mode,
    input  wire logic                          dev_usb3_cap,
    input  wire logic                          reorder_en,
    // Frames from the USB bus interface
    input  wire logic                          usb_in_valid,
    output logic                               usb_in_ready,
    input  wire logic [bridge_pkg::DATA_W-1:0] usb_in_data,
    input  wire logic                          usb_in_last,
    // Frames to the USB bus interface
    output logic                               usb_out_valid,
    input  wire logic                          usb_out_ready,
    output logic      [bridge_pkg::DATA_W-1:0] usb_out_data,
    output logic                               usb_out_last,
    // Units to the MAC with scheduling info
    output logic                               mac_tx_valid,
    input  wire logic                          mac_tx_ready,
    output logic      [bridge_pkg::DATA_W-1:0] mac_tx_data,
    output logic                               mac_tx_last,
    output logic      [1:0]                    mac_tx_kind,
    output bridge_pkg::xfer_t                  mac_tx_xfer,
    output logic                               mac_tx_usb3,
    output bridge_pkg::seq_t                   mac_tx_seq,
    output logic                               mac_priv_res_req,
    // Units from the MAC
    input  wire logic                          mac_rx_valid,
    output logic                               mac_rx_ready,
    input  wire logic [bridge_pkg::DATA_W-1:0] mac_rx_data,
    input  wire logic                          mac_rx_last
);
    import bridge_pkg::*;

    typedef struct packed {
        logic        in_busy;
        logic [1:0]  in_kind;
        logic        in_drop;
        seq_t        in_seq;
        logic        tx_busy;
        logic [1:0]  tx_sel;
        seq_t        tx_exp;
        logic        rx_busy;
        logic [1:0]  rx_kind;
        logic        rx_drop;
        logic        ob_busy;
        logic [1:0]  ob_sel;
        seq_t        ob_exp;
        logic        tv;
        logic [DATA_W-1:0] td;
        logic        tl;
        logic [1:0]  tk;
        xfer_t       tx_class;
        logic        tu3;
        seq_t        tseq;
        logic        uv;
        logic [DATA_W-1:0] ud;
        logic        ul;
        logic        pr;
    } st_t;

    st_t              s_reg;
    st_t              s_next;
    logic [NUM_Q-1:0] up_wv;
    logic [NUM_Q-1:0] up_wr;
    logic [NUM_Q-1:0] up_rv;
    logic [NUM_Q-1:0] up_rr;
    logic [NUM_Q-1:0] dn_wv;
    logic [NUM_Q-1:0] dn_wr;
    logic [NUM_Q-1:0] dn_rv;
    logic [NUM_Q-1:0] dn_rr;
    logic [FIFO_W-1:0] up_wd;
    logic [FIFO_W-1:0] dn_wd;
    logic [FIFO_W-1:0] up_rd [NUM_Q];
    logic [FIFO_W-1:0] dn_rd [NUM_Q];
    logic [1:0]       in_k;
    logic [1:0]       rx_k;
    logic [1:0]       tx_pick;
    logic [1:0]       ob_pick;
    logic             in_drop_c;
    logic             rx_drop_c;
    logic             tx_found;
    logic             ob_found;
    logic             tx_take;
    logic             ob_take;
    logic             usb3_ok;
    logic [FIFO_W-1:0] tx_word;
    logic [FIFO_W-1:0] ob_word;

    // One buffer per packet kind in each direction
    for (genvar q = 0; q < NUM_Q; q++) begin : g_q
        packet_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_up (
            .clk       (clk),
            .rst       (rst),
            .in_valid  (up_wv[q]),
            .in_ready  (up_wr[q]),
            .in_data   (up_wd),
            .out_valid (up_rv[q]),
            .out_ready (up_rr[q]),
            .out_data  (up_rd[q])
        );
        packet_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_dn (
            .clk       (clk),
            .rst       (rst),
            .in_valid  (dn_wv[q]),
            .in_ready  (dn_wr[q]),
            .in_data   (dn_wd),
            .out_valid (dn_rv[q]),
            .out_ready (dn_rr[q]),
            .out_data  (dn_rd[q])
        );
    end

    // Whole next-state of the bridge
    always_comb begin
        s_next = s_reg;
        usb3_ok = host_mode | dev_usb3_cap;

        // USB side intake: route each packet by its header kind
        in_k = s_reg.in_busy ? s_reg.in_kind : usb_in_data[KIND_LSB +: 2];
        in_drop_c = s_reg.in_busy ? s_reg.in_drop
                  : (in_k == KIND_NONE) || (!host_mode && in_k == KIND_TOKEN);
        usb_in_ready = in_drop_c;
        up_wv = '0;
        for (int q = 0; q < NUM_Q; q++) begin
            if (in_k == 2'(q)) begin
                usb_in_ready = in_drop_c || up_wr[q];
                up_wv[q] = usb_in_valid && !in_drop_c;
            end
        end
        // Arrival order stamped so the far end can restore it
        up_wd = {usb_in_last, usb_in_data};
        if (!s_reg.in_busy) begin
            up_wd[SEQ_LSB +: SEQ_W] = s_reg.in_seq;
        end
        if (usb_in_valid && usb_in_ready) begin
            if (!s_reg.in_busy) begin
                s_next.in_kind = in_k;
                s_next.in_drop = in_drop_c;
                if (!in_drop_c) begin
                    s_next.in_seq = s_reg.in_seq + SEQ_ONE;
                end
            end
            s_next.in_busy = !usb_in_last;
        end

        // MAC side output: one packet per unit, kinds never merged
        tx_found = 1'b0;
        tx_pick = s_reg.tx_sel;
        if (s_reg.tx_busy) begin
            tx_found = up_rv[s_reg.tx_sel];
        end else if (reorder_en && up_rv[s_reg.tx_sel]) begin
            tx_found = 1'b1; // Stay on one queue to cut turnarounds
        end else begin
            for (int q = NUM_Q - 1; q >= 0; q--) begin
                if (up_rv[q] && (reorder_en || up_rd[q][SEQ_LSB +: SEQ_W] == s_reg.tx_exp)) begin
                    tx_found = 1'b1;
                    tx_pick = 2'(q);
                end
            end
        end
        tx_word = up_rd[tx_pick];
        tx_take = tx_found && (!s_reg.tv || mac_tx_ready);
        up_rr = '0;
        for (int q = 0; q < NUM_Q; q++) begin
            up_rr[q] = tx_take && tx_pick == 2'(q);
        end
        if (mac_tx_ready) begin
            s_next.tv = 1'b0;
        end
        if (tx_take) begin
            s_next.tv = 1'b1;
            s_next.td = tx_word[DATA_W-1:0];
            s_next.tl = tx_word[DATA_W];
            s_next.tx_sel = tx_pick;
            s_next.tx_busy = !tx_word[DATA_W];
            // Header word carries the scheduling info for the whole unit
            if (!s_reg.tx_busy) begin
                s_next.tk = tx_word[KIND_LSB +: 2];
                s_next.tx_class = xfer_t'(tx_word[XFER_LSB +: 2]);
                s_next.tu3 = usb3_ok && tx_word[REV_BIT];
                s_next.tseq = tx_word[SEQ_LSB +: SEQ_W];
                s_next.tx_exp = tx_word[SEQ_LSB +: SEQ_W] + SEQ_ONE;
            end
        end

        // MAC side intake: host drops stray tokens, device keeps all three
        rx_k = s_reg.rx_busy ? s_reg.rx_kind : mac_rx_data[KIND_LSB +: 2];
        rx_drop_c = s_reg.rx_busy ? s_reg.rx_drop
                  : (rx_k == KIND_NONE) || (host_mode && rx_k == KIND_TOKEN);
        mac_rx_ready = rx_drop_c;
        dn_wv = '0;
        for (int q = 0; q < NUM_Q; q++) begin
            if (rx_k == 2'(q)) begin
                mac_rx_ready = rx_drop_c || dn_wr[q];
                dn_wv[q] = mac_rx_valid && !rx_drop_c;
            end
        end
        dn_wd = {mac_rx_last, mac_rx_data};
        if (mac_rx_valid && mac_rx_ready) begin
            if (!s_reg.rx_busy) begin
                s_next.rx_kind = rx_k;
                s_next.rx_drop = rx_drop_c;
            end
            s_next.rx_busy = !mac_rx_last;
        end

        // USB side output: restore sequence order across the queues
        ob_found = 1'b0;
        ob_pick = s_reg.ob_sel;
        if (s_reg.ob_busy) begin
            ob_found = dn_rv[s_reg.ob_sel];
        end else begin
            for (int q = NUM_Q - 1; q >= 0; q--) begin
                if (dn_rv[q] && dn_rd[q][SEQ_LSB +: SEQ_W] == s_reg.ob_exp) begin
                    ob_found = 1'b1;
                    ob_pick = 2'(q);
                end
            end
            // A gap would deadlock: resync once the input stalls or idles
            if (!ob_found && (|(~dn_wr) || !mac_rx_valid)) begin
                for (int q = NUM_Q - 1; q >= 0; q--) begin
                    if (dn_rv[q]) begin
                        ob_found = 1'b1;
                        ob_pick = 2'(q);
                    end
                end
            end
        end
        ob_word = dn_rd[ob_pick];
        ob_take = ob_found && (!s_reg.uv || usb_out_ready);
        dn_rr = '0;
        for (int q = 0; q < NUM_Q; q++) begin
            dn_rr[q] = ob_take && ob_pick == 2'(q);
        end
        if (usb_out_ready) begin
            s_next.uv = 1'b0;
        end
        if (ob_take) begin
            s_next.uv = 1'b1;
            s_next.ud = ob_word[DATA_W-1:0];
            s_next.ul = ob_word[DATA_W];
            s_next.ob_sel = ob_pick;
            s_next.ob_busy = !ob_word[DATA_W];
            if (!s_reg.ob_busy) begin
                s_next.ob_exp = ob_word[SEQ_LSB +: SEQ_W] + SEQ_ONE;
            end
        end

        // Traffic queued both ways on a 3.0 link wants a private slot
        s_next.pr = usb3_ok && (|up_rv) && (|dn_rv);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign mac_tx_valid     = s_reg.tv;
    assign mac_tx_data      = s_reg.td;
    assign mac_tx_last      = s_reg.tl;
    assign mac_tx_kind      = s_reg.tk;
    assign mac_tx_xfer      = s_reg.tx_class;
    assign mac_tx_usb3      = s_reg.tu3;
    assign mac_tx_seq       = s_reg.tseq;
    assign mac_priv_res_req = s_reg.pr;
    assign usb_out_valid    = s_reg.uv;
    assign usb_out_data     = s_reg.ud;
    assign usb_out_last     = s_reg.ul;
endmodule
`default_nettype wire

// ===== bench/bridge_assertions.sv
// Port-level checks on the adaptation bridge.
// Assumes the bind below and the header word layout of bridge_pkg.
`default_nettype none
module bridge_assertions (
    // Clock, reset, configuration
    input wire logic                          clk,
    input wire logic                          rst,
    input wire logic                          host_mode,
    input wire logic                          dev_usb3_cap,
    input wire logic                          reorder_en,
    // MAC side
    input wire logic                          mac_tx_valid,
    input wire logic                          mac_tx_ready,
    input wire logic [bridge_pkg::DATA_W-1:0] mac_tx_data,
    input wire logic                          mac_tx_last,
    input wire logic [1:0]                    mac_tx_kind,
    input wire logic                          mac_tx_usb3,
    input wire bridge_pkg::seq_t              mac_tx_seq,
    input wire logic                          mac_priv_res_req,
    input wire logic                          mac_rx_valid,
    input wire logic                          mac_rx_ready,
    input wire logic [bridge_pkg::DATA_W-1:0] mac_rx_data,
    input wire logic                          mac_rx_last,
    // USB side
    input wire logic                          usb_out_valid,
    input wire logic                          usb_out_ready,
    input wire logic [bridge_pkg::DATA_W-1:0] usb_out_data,
    input wire logic                          usb_out_last
);
    timeunit 1ns;
    timeprecision 1ns;
    import bridge_pkg::*;
    logic tx_first_reg;
    logic rx_first_reg;
    logic out_first_reg;
    seq_t last_seq_reg;
    // Packet start trackers; the stamp count starts so that the first unit is 0
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_first_reg  <= 1'b1;
            rx_first_reg  <= 1'b1;
            out_first_reg <= 1'b1;
            last_seq_reg  <= SEQ_RST - SEQ_ONE;
        end else begin
            if (mac_tx_valid && mac_tx_ready) tx_first_reg <= mac_tx_last;
            if (mac_tx_valid && mac_tx_ready && tx_first_reg) last_seq_reg <= mac_tx_seq;
            if (mac_rx_valid && mac_rx_ready) rx_first_reg <= mac_rx_last;
            if (usb_out_valid && usb_out_ready) out_first_reg <= usb_out_last;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_tx_stall; mac_tx_valid && !mac_tx_ready; endsequence
    sequence s_tx_held; mac_tx_valid && $stable(mac_tx_data) && $stable(mac_tx_last) && $stable(mac_tx_kind); endsequence
    property p_tx_hold; s_tx_stall |=> s_tx_held; endproperty
    property p_unit_info; mac_tx_valid && mac_tx_ready && !mac_tx_last |=> $stable(mac_tx_kind) && $stable(mac_tx_seq) && $stable(mac_tx_usb3); endproperty
    property p_usb_hold; usb_out_valid && !usb_out_ready |=> usb_out_valid && $stable(usb_out_data) && $stable(usb_out_last); endproperty
    property p_usb3; mac_tx_valid && !host_mode && !dev_usb3_cap |-> !mac_tx_usb3; endproperty
    property p_tx_kind; mac_tx_valid && tx_first_reg |-> mac_tx_kind == mac_tx_data[1:0] && mac_tx_seq == mac_tx_data[7:4]
        && mac_tx_kind != KIND_NONE && (host_mode || mac_tx_kind != KIND_TOKEN); endproperty
    property p_seq; mac_tx_valid && tx_first_reg && !reorder_en |-> mac_tx_seq == last_seq_reg + SEQ_ONE; endproperty
    property p_out_kind; usb_out_valid && out_first_reg |-> usb_out_data[1:0] != KIND_NONE
        && !(host_mode && usb_out_data[1:0] == KIND_TOKEN); endproperty
    property p_rx_drop; mac_rx_valid && rx_first_reg && mac_rx_data[1:0] == KIND_NONE |-> mac_rx_ready; endproperty
    property p_priv; mac_priv_res_req |-> host_mode || dev_usb3_cap; endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("mac word changed while stalled");
    a_unit_info: assert property (p_unit_info) else $error("unit info changed inside a unit");
    a_usb_hold: assert property (p_usb_hold) else $error("usb word changed while stalled");
    a_usb3: assert property (p_usb3) else $error("usb3 flag without capability");
    a_tx_kind: assert property (p_tx_kind) else $error("bad unit header info");
    a_seq: assert property (p_seq) else $error("unit stamp out of order");
    a_out_kind: assert property (p_out_kind) else $error("packet kind not expected on usb");
    a_rx_drop: assert property (p_rx_drop) else $error("invalid packet not swallowed");
    a_priv: assert property (p_priv) else $error("private reservation not allowed");
endmodule
bind usb_wireless_adaptation_bridge bridge_assertions chk (.clk(clk), .rst(rst), .host_mode(host_mode),
    .dev_usb3_cap(dev_usb3_cap), .reorder_en(reorder_en), .mac_tx_valid(mac_tx_valid), .mac_tx_ready(mac_tx_ready),
    .mac_tx_data(mac_tx_data), .mac_tx_last(mac_tx_last), .mac_tx_kind(mac_tx_kind), .mac_tx_usb3(mac_tx_usb3),
    .mac_tx_seq(mac_tx_seq), .mac_priv_res_req(mac_priv_res_req), .mac_rx_valid(mac_rx_valid),
    .mac_rx_ready(mac_rx_ready), .mac_rx_data(mac_rx_data), .mac_rx_last(mac_rx_last),
    .usb_out_valid(usb_out_valid), .usb_out_ready(usb_out_ready), .usb_out_data(usb_out_data),
    .usb_out_last(usb_out_last));
`default_nettype wire

// ===== bench/mac_model.sv
// Behavioural wireless MAC facing the bridge.
// Assumes the bench calls send_word at one ns past a rising edge.
`default_nettype none
module mac_model (
    // Clock, reset, test control
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          stall,
    // Units from the bridge
    input  wire logic                          mac_tx_valid,
    output logic                               mac_tx_ready,
    input  wire logic                          mac_priv_res_req,
    // Units to the bridge
    output logic                               mac_rx_valid,
    input  wire logic                          mac_rx_ready,
    output logic      [bridge_pkg::DATA_W-1:0] mac_rx_data,
    output logic                               mac_rx_last
);
    timeunit 1ns;
    timeprecision 1ns;
    import bridge_pkg::*;
    logic rnd;
    initial {rnd, mac_rx_valid, mac_rx_last, mac_rx_data} = 35'h0;
    // Random acceptance; a requested private slot keeps mac_tx_ready high unless stalled
    always @(posedge clk) #1 rnd = $urandom_range(0, 3) != 0;
    assign mac_tx_ready = !stall && (mac_priv_res_req || rnd);
    // One word, held until the bridge takes it
    task send_word(input logic [DATA_W-1:0] d, input logic l);
        {mac_rx_valid, mac_rx_data, mac_rx_last} = {1'b1, d, l};
        do @(posedge clk); while (mac_rx_ready !== 1'b1);
        #1;
    endtask
    // Released line shows the inverse, never a stale word
    task idle();
        {mac_rx_valid, mac_rx_data, mac_rx_last} = {1'b0, ~mac_rx_data, ~mac_rx_last};
        @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// ===== bench/test_usb_wireless_adaptation_bridge.sv
// Self-checking bench for the adaptation bridge.
// Assumes mac_model on the MAC side; the bench plays the USB bus interface.
`default_nettype none
module test_usb_wireless_adaptation_bridge;
    timeunit 1ns;
    timeprecision 1ns;
    import bridge_pkg::*;
    logic clk, rst, host_mode, dev_usb3_cap, reorder_en, stall, ustall;
    logic usb_in_valid, usb_in_ready, usb_in_last, usb_out_valid, usb_out_ready, usb_out_last;
    logic mac_tx_valid, mac_tx_ready, mac_tx_last, mac_tx_usb3, mac_priv_res_req, mac_rx_valid, mac_rx_ready, mac_rx_last;
    logic [DATA_W-1:0] usb_in_data, usb_out_data, mac_tx_data, mac_rx_data;
    logic [1:0]        mac_tx_kind;
    xfer_t             mac_tx_xfer;
    seq_t              mac_tx_seq, tx_seq, rx_seq;
    logic [41:0]       q_mac[$];
    logic [41:0]       q_usb[$];
    int                error_cnt, comparisons, cycles;
    usb_wireless_adaptation_bridge DUT (.clk(clk), .rst(rst), .host_mode(host_mode), .dev_usb3_cap(dev_usb3_cap),
        .reorder_en(reorder_en), .usb_in_valid(usb_in_valid), .usb_in_ready(usb_in_ready), .usb_in_data(usb_in_data),
        .usb_in_last(usb_in_last), .usb_out_valid(usb_out_valid), .usb_out_ready(usb_out_ready),
        .usb_out_data(usb_out_data), .usb_out_last(usb_out_last), .mac_tx_valid(mac_tx_valid),
        .mac_tx_ready(mac_tx_ready), .mac_tx_data(mac_tx_data), .mac_tx_last(mac_tx_last), .mac_tx_kind(mac_tx_kind),
        .mac_tx_xfer(mac_tx_xfer), .mac_tx_usb3(mac_tx_usb3), .mac_tx_seq(mac_tx_seq),
        .mac_priv_res_req(mac_priv_res_req), .mac_rx_valid(mac_rx_valid), .mac_rx_ready(mac_rx_ready),
        .mac_rx_data(mac_rx_data), .mac_rx_last(mac_rx_last));
    mac_model mac (.clk(clk), .rst(rst), .stall(stall), .mac_tx_valid(mac_tx_valid), .mac_tx_ready(mac_tx_ready),
        .mac_priv_res_req(mac_priv_res_req), .mac_rx_valid(mac_rx_valid), .mac_rx_ready(mac_rx_ready),
        .mac_rx_data(mac_rx_data), .mac_rx_last(mac_rx_last));
    always #25 clk = ~clk;
    task cmp_word(input logic [41:0] exp, input logic [41:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task cmp_flag(input logic exp, input logic got);
        cmp_word({41'h0, exp}, {41'h0, got});
    endtask
    task stop_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    // USB sink stalls at random, or fully when ustall is set
    always @(posedge clk) #1 usb_out_ready = !ustall && $urandom_range(0, 2) != 0;
    // Oldest note against every word handed over
    always @(posedge clk) begin
        if (mac_tx_valid === 1'b1 && mac_tx_ready === 1'b1)
            cmp_word(q_mac.pop_front(), {mac_tx_data, mac_tx_last, mac_tx_kind, mac_tx_xfer, mac_tx_usb3, mac_tx_seq});
        if (usb_out_valid === 1'b1 && usb_out_ready === 1'b1)
            cmp_word(q_usb.pop_front(), {9'h0, usb_out_data, usb_out_last});
    end
    // One USB packet in; the bridge restamps bits 7:4 of the header
    task usb_pkt(input logic [1:0] k, input logic [1:0] x, input logic u3, input int n);
        logic [DATA_W-1:0] w;
        logic keep;
        keep = k != KIND_NONE && (host_mode || k != KIND_TOKEN);
        for (int i = 0; i <= n; i++) begin
            w = $urandom();
            if (i == 0) {w[8], w[3:0]} = {u3, x, k};
            {usb_in_valid, usb_in_data, usb_in_last} = {1'b1, w, i == n};
            if (i == 0) w[7:4] = tx_seq;
            if (keep) q_mac.push_back({w, i == n, k, x, u3 & (host_mode | dev_usb3_cap), tx_seq});
            do @(posedge clk); while (usb_in_ready !== 1'b1);
            #1;
        end
        {usb_in_valid, usb_in_data} = {1'b0, ~usb_in_data};
        if (keep) tx_seq++;
        @(posedge clk);
        #1;
    endtask
    // One MAC unit in; dropped units carry a stamp that never matches
    task mac_pkt(input logic [1:0] k, input int n);
        logic [DATA_W-1:0] w;
        logic keep;
        keep = k != KIND_NONE && !(host_mode && k == KIND_TOKEN);
        for (int i = 0; i <= n; i++) begin
            w = $urandom();
            if (i == 0) {w[7:4], w[1:0]} = {keep ? rx_seq : rx_seq + 4'h8, k};
            if (keep) q_usb.push_back({9'h0, w, i == n});
            mac.send_word(w, i == n);
        end
        mac.idle();
        if (keep) rx_seq++;
    endtask
    task drain();
        for (int i = 0; i < 2000 && q_mac.size() + q_usb.size() > 0; i++) @(posedge clk);
        repeat (5) @(posedge clk);
        #1;
    endtask
    // Every kind and transfer class, both directions at once
    task traffic();
        fork
            for (int i = 0; i < 16; i++) usb_pkt(i[3:2], i[1:0], 1'($urandom()), $urandom_range(0, 3));
            for (int i = 0; i < 16; i++) mac_pkt(i[1:0], $urandom_range(0, 3));
        join
        drain();
    endtask
    initial begin
        {clk, rst, host_mode, dev_usb3_cap, reorder_en, stall, ustall, usb_in_valid, usb_in_last} = 9'h040;
        {usb_in_data, usb_out_ready, tx_seq, rx_seq} = {32'h0, 1'b0, SEQ_RST, SEQ_RST};
        void'($urandom(32'h3065));
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        // Device without 3.0, device with 3.0, then host
        for (int m = 0; m < 3; m++) begin
            {host_mode, dev_usb3_cap} = m[1:0];
            traffic();
        end
        // Both directions blocked: buffers fill and refuse
        {stall, ustall} = 2'h3;
        fork
            usb_pkt(KIND_DATA, XFER_BULK, 1'b1, 20);
            mac_pkt(KIND_DATA, 20);
        join_none
        repeat (60) @(posedge clk);
        cmp_flag(1'b0, usb_in_ready);
        cmp_flag(1'b0, mac_rx_ready);
        cmp_flag(1'b1, mac_priv_res_req);
        #1 {stall, ustall} = 2'h0;
        wait fork;
        drain();
        // Reordering allowed, one queue only so the order stays known
        reorder_en = 1'b1;
        repeat (3) usb_pkt(KIND_HSHAKE, XFER_INTR, 1'b0, 2);
        drain();
        reorder_en = 1'b0;
        // Reset in mid-run clears the stamps
        rst = 1'b1;
        repeat (3) @(posedge clk);
        cmp_flag(1'b0, mac_tx_valid | usb_out_valid | mac_priv_res_req);
        #1 {rst, tx_seq, rx_seq} = {1'b0, SEQ_RST, SEQ_RST};
        traffic();
        cmp_flag(1'b1, q_mac.size() + q_usb.size() == 0);
        stop_test();
    end
endmodule
`default_nettype wire
